// [verilog/tsr_regime_select.sv]
// Scheme, granule, stage and address-range selection for one translation context.
// Assumes synchronous inputs on clk and a register master that never needs a wait.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
// Function
// - Short scheme walks 32-bit descriptors
// - Short output 32 bits, 40 with big pages
// - Short scheme only at first stage
// - Long32 uses 64-bit descriptors, 40-bit output
// - Wide scheme 64-bit descriptors, 49-bit input
// - Wide scheme 48-bit output, two ranges
// - Both 32-bit schemes use 4KB granule
// - Long32 first stage 4KB, second stage also 4KB only
// - Wide scheme granule 4KB, 16KB or 64KB
// - Guest first stage splits two subranges
// - Lower range starts at zero upward
// - Upper range ends at all ones
// - Wide scheme always gap, long32 optional
// - Bit 48 selects lower or upper
// - Two stages only for non-secure guest
// - Monitor regime only via monitor bank
// - Hypervisor regimes only on hyp banks, long32 unless wide
// - Second-stage-only context for IPA space
// - Guest with hypervisor: stage 2 long32/wide
// - Wide addressing uses wide at all stages
module tsr_regime_select (
	input wire logic clk,
	input wire logic rst_n,
	input wire tsr_pkg::tsr_bus_type bus,
	output logic [31:0] rdata,
	input wire tsr_pkg::tsr_lookup_type lookup,
	output tsr_pkg::tsr_result_type result_reg,
	output logic config_error,
	output logic [1:0] stages
);
	import tsr_pkg::*;

	// Software-written control word and range sizes.
	logic [31:0] ctrl_reg;
	logic [5:0] low_size_reg;
	logic [5:0] up_size_reg;
	// Sticky record of lookups that fell into the gap.
	logic gap_seen_reg;
	logic [31:0] rdata_reg;

	// Decoded fields of the control word.
	tsr_scheme_type s1_scheme;
	tsr_scheme_type s2_scheme;
	tsr_regime_type regime;
	tsr_granule_type gran;
	tsr_granule_type s2_gran;
	logic hyp_bank;
	logic mon_bank;
	logic wide_mode;
	assign s1_scheme = tsr_scheme_type'(ctrl_reg[TSR_CTRL_S1SCH_LSB +: 2]);
	assign s2_scheme = tsr_scheme_type'(ctrl_reg[TSR_CTRL_S2SCH_LSB +: 2]);
	assign regime = tsr_regime_type'(ctrl_reg[TSR_CTRL_REGIME_LSB +: 3]);
	assign gran = tsr_granule_type'(ctrl_reg[TSR_CTRL_GRAN_LSB +: 2]);
	assign s2_gran = tsr_granule_type'(ctrl_reg[TSR_CTRL_S2GRAN_LSB +: 2]);
	assign hyp_bank = ctrl_reg[TSR_CTRL_HYPBANK_BIT];
	assign mon_bank = ctrl_reg[TSR_CTRL_MONBANK_BIT];
	assign wide_mode = ctrl_reg[TSR_CTRL_WIDE_BIT];

	// Register writes; the status bit is handled in its own process.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= TSR_CTRL_RESET;
			low_size_reg <= TSR_SIZE_RESET;
			up_size_reg <= TSR_SIZE_RESET;
		end else if (bus.wr) begin
			// Unmapped addresses are ignored on write.
			if (bus.addr == TSR_ADDR_CTRL) begin
				ctrl_reg <= bus.wdata;
			end else if (bus.addr == TSR_ADDR_RANGE) begin
				low_size_reg <= bus.wdata[TSR_RANGE_LOW_LSB +: 6];
				up_size_reg <= bus.wdata[TSR_RANGE_UP_LSB +: 6];
			end
		end
	end

	// Stage arrangement per regime.
	logic stage_bad;
	always_comb begin
		stage_bad = 1'b0;
		unique case (regime)
			TSR_RG_MONITOR: begin
				stages = TSR_ST_S1_BYPASS;
				stage_bad = !mon_bank;
			end
			TSR_RG_SEC_GUEST, TSR_RG_NS_GUEST_NOHYP: begin
				stages = TSR_ST_S1_BYPASS;
				stage_bad = hyp_bank || mon_bank;
			end
			TSR_RG_NS_HYP, TSR_RG_SEC_HYP: begin
				stages = TSR_ST_S1_BYPASS;
				stage_bad = !hyp_bank || (!wide_mode && s1_scheme != TSR_SCH_LONG32);
			end
			// two stages for the non-secure guest
			TSR_RG_NS_GUEST_HYP: begin
				stages = TSR_ST_S1_S2;
				stage_bad = hyp_bank || mon_bank;
			end
			TSR_RG_NS_IPA: begin
				stages = TSR_ST_S2_ONLY;
				stage_bad = hyp_bank || mon_bank;
			end
			default: begin
				stages = TSR_ST_NONE;
				stage_bad = 1'b1;
			end
		endcase
	end

	// Scheme legality per stage.
	logic s1_used;
	logic s2_used;
	logic scheme_bad;
	assign s1_used = (stages == TSR_ST_S1_BYPASS) || (stages == TSR_ST_S1_S2);
	assign s2_used = (stages == TSR_ST_S1_S2) || (stages == TSR_ST_S2_ONLY);
	always_comb begin
		scheme_bad = 1'b0;
		if (s1_used && s1_scheme == TSR_SCH_RSVD) begin
			scheme_bad = 1'b1;
		end
		// no short scheme at stage two
		if (s2_used && (s2_scheme == TSR_SCH_SHORT || s2_scheme == TSR_SCH_RSVD)) begin
			scheme_bad = 1'b1;
		end
		// no wide scheme at two-stage guest stage one outside wide mode
		if (!wide_mode && stages == TSR_ST_S1_S2 && s1_scheme == TSR_SCH_WIDE64) begin
			scheme_bad = 1'b1;
		end
		if (wide_mode && s1_used && s1_scheme != TSR_SCH_WIDE64) begin
			scheme_bad = 1'b1;
		end
		if (wide_mode && s2_used && s2_scheme != TSR_SCH_WIDE64) begin
			scheme_bad = 1'b1;
		end
	end

	// Granule legality; the 32-bit schemes are fixed at 4KB.
	logic gran_bad;
	always_comb begin
		gran_bad = 1'b0;
		if (s1_used && s1_scheme != TSR_SCH_WIDE64 && gran != TSR_GR_4K) begin
			gran_bad = 1'b1;
		end
		if (s2_used && s2_scheme == TSR_SCH_LONG32 && s2_gran != TSR_GR_4K) begin
			gran_bad = 1'b1;
		end
		if (s1_used && s1_scheme == TSR_SCH_WIDE64 && gran == TSR_GR_RSVD) begin
			gran_bad = 1'b1;
		end
		if (s2_used && s2_scheme == TSR_SCH_WIDE64 && s2_gran == TSR_GR_RSVD) begin
			gran_bad = 1'b1;
		end
	end
	assign config_error = stage_bad || scheme_bad || gran_bad;

	// Width figures for the walking scheme: stage two when only stage two is used, else stage one.
	tsr_scheme_type walk_scheme;
	logic [6:0] desc_width;
	logic [5:0] in_width;
	logic [5:0] out_width;
	assign walk_scheme = (stages == TSR_ST_S2_ONLY) ? s2_scheme : s1_scheme;
	always_comb begin
		unique case (walk_scheme)
			TSR_SCH_SHORT: begin
				desc_width = TSR_DESC_32;
				in_width = TSR_IA_32;
				out_width = lookup.big_page ? TSR_OA_SHORT_BIG : TSR_OA_SHORT;
			end
			TSR_SCH_LONG32: begin
				desc_width = TSR_DESC_64;
				in_width = TSR_IA_32;
				out_width = TSR_OA_LONG32;
			end
			TSR_SCH_WIDE64: begin
				desc_width = TSR_DESC_64;
				in_width = TSR_IA_WIDE64;
				out_width = TSR_OA_WIDE64;
			end
			default: begin
				desc_width = 7'h00;
				in_width = 6'h00;
				out_width = 6'h00;
			end
		endcase
	end

	// Range decode; sizes give the address bits each subrange spans.
	logic split_active;
	logic [63:0] va;
	logic lo_hit;
	logic up_hit;
	logic [63:0] lo_limit;
	logic [63:0] up_base;
	assign split_active = (regime == TSR_RG_NS_GUEST_HYP || regime == TSR_RG_NS_GUEST_NOHYP
		|| regime == TSR_RG_SEC_GUEST) && s1_used;
	assign va = lookup.addr;
	assign lo_limit = 64'h0000_0000_0000_0001 << low_size_reg;
	// upper range down from all ones
	assign up_base = ~((64'h0000_0000_0000_0001 << up_size_reg) - 64'h0000_0000_0000_0001);
	always_comb begin
		lo_hit = 1'b0;
		up_hit = 1'b0;
		if (walk_scheme == TSR_SCH_WIDE64) begin
			// bit 48 picks the subrange; upper-range addresses are sign-extended from it, lower ones are compared in full
			if (!va[TSR_VA_SEL_BIT]) begin
				lo_hit = va < lo_limit;
			end else begin
				up_hit = {{15{1'b1}}, va[TSR_VA_W-1:0]} >= up_base;
			end
		end else begin
			lo_hit = va[31:0] < lo_limit[31:0] || low_size_reg >= 6'h20;
			up_hit = !lo_hit && {32'hFFFF_FFFF, va[31:0]} >= up_base;
			if (!split_active) begin
				lo_hit = 1'b1;
				up_hit = 1'b0;
			end
		end
		if (walk_scheme == TSR_SCH_WIDE64 && !split_active) begin
			lo_hit = !va[TSR_VA_SEL_BIT];
			up_hit = 1'b0;
		end
	end

	// Registered lookup result; a gap address faults instead of translating.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= '0;
		end else begin
			result_reg.valid <= lookup.valid;
			result_reg.lower_hit <= lookup.valid && lo_hit && !config_error;
			result_reg.upper_hit <= lookup.valid && up_hit && !config_error;
			result_reg.fault <= lookup.valid && (config_error || (!lo_hit && !up_hit));
		end
	end

	// Sticky gap flag; a new event wins over a clearing write.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_seen_reg <= 1'b0;
		end else if (lookup.valid && !lo_hit && !up_hit) begin
			gap_seen_reg <= 1'b1;
		end else if (bus.wr && bus.addr == TSR_ADDR_STATUS && bus.wdata[0]) begin
			gap_seen_reg <= 1'b0;
		end
	end

	// Read data in the cycle after the read strobe; unmapped reads return zero.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (bus.rd) begin
			unique case (bus.addr)
				TSR_ADDR_CTRL: rdata_reg <= ctrl_reg;
				TSR_ADDR_RANGE: rdata_reg <= {18'h00000, up_size_reg, 2'h0, low_size_reg};
				TSR_ADDR_STATUS: rdata_reg <= {28'h0000000, stages, config_error, gap_seen_reg};
				TSR_ADDR_WIDTHS: rdata_reg <= {9'h000, desc_width, 2'h0, out_width, 2'h0, in_width};
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end
	assign rdata = rdata_reg;

	// Checks.
	chk_short_stage2: assert property (@(posedge clk) disable iff (!rst_n)
		(s2_used && s2_scheme == TSR_SCH_SHORT) |-> config_error)
		else $error("short scheme accepted at stage two");
	chk_two_stage_regime: assert property (@(posedge clk) disable iff (!rst_n)
		(stages == TSR_ST_S1_S2) |-> (regime == TSR_RG_NS_GUEST_HYP))
		else $error("two stages outside guest regime");
	chk_monitor_bank: assert property (@(posedge clk) disable iff (!rst_n)
		(regime == TSR_RG_MONITOR && !mon_bank) |-> config_error)
		else $error("monitor regime off monitor bank");
	chk_hyp_long: assert property (@(posedge clk) disable iff (!rst_n)
		(regime == TSR_RG_NS_HYP && !wide_mode && s1_scheme == TSR_SCH_SHORT) |-> config_error)
		else $error("hypervisor regime with short scheme");
	chk_gap_fault: assert property (@(posedge clk) disable iff (!rst_n)
		(lookup.valid && !lo_hit && !up_hit) |=> (result_reg.fault && gap_seen_reg))
		else $error("gap address not faulted");
	chk_wide_width: assert property (@(posedge clk) disable iff (!rst_n)
		(walk_scheme == TSR_SCH_WIDE64) |-> (in_width == TSR_IA_WIDE64 && desc_width == TSR_DESC_64))
		else $error("wide scheme widths wrong");
	chk_short_width: assert property (@(posedge clk) disable iff (!rst_n)
		(walk_scheme == TSR_SCH_SHORT && !lookup.big_page) |-> (out_width == TSR_OA_SHORT))
		else $error("short output width wrong");
	chk_gran_32: assert property (@(posedge clk) disable iff (!rst_n)
		(s1_used && s1_scheme == TSR_SCH_LONG32 && gran != TSR_GR_4K) |-> config_error)
		else $error("non 4KB granule for 32-bit scheme");
	chk_read_once: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(bus.rd) |-> (rdata == 32'h0000_0000))
		else $error("read data outside its cycle");
	cov_two_stage: cover property (@(posedge clk) disable iff (!rst_n) stages == TSR_ST_S1_S2 && !config_error);
	cov_upper_hit: cover property (@(posedge clk) disable iff (!rst_n) result_reg.upper_hit);
	cov_gap: cover property (@(posedge clk) disable iff (!rst_n) result_reg.fault && !config_error);
endmodule

// [verilog/tsr_pkg.sv]
// Package for the translation scheme and regime selector.
// Assumes a single system clock domain and a plain register port master.
package tsr_pkg;
	// Translation scheme encodings.
	typedef enum logic [1:0] {
		TSR_SCH_SHORT = 2'h0,
		TSR_SCH_LONG32 = 2'h1,
		TSR_SCH_WIDE64 = 2'h2,
		TSR_SCH_RSVD = 2'h3
	} tsr_scheme_type;
	// Translation regime encodings.
	typedef enum logic [2:0] {
		TSR_RG_MONITOR = 3'h0,
		TSR_RG_SEC_GUEST = 3'h1,
		TSR_RG_NS_HYP = 3'h2,
		TSR_RG_SEC_HYP = 3'h3,
		TSR_RG_NS_GUEST_NOHYP = 3'h4,
		TSR_RG_NS_GUEST_HYP = 3'h5,
		TSR_RG_NS_IPA = 3'h6,
		TSR_RG_RSVD = 3'h7
	} tsr_regime_type;
	// Stage arrangement encodings.
	typedef enum logic [1:0] {
		TSR_ST_S1_BYPASS = 2'h0,
		TSR_ST_S1_S2 = 2'h1,
		TSR_ST_S2_ONLY = 2'h2,
		TSR_ST_NONE = 2'h3
	} tsr_stages_type;
	// Granule encodings.
	typedef enum logic [1:0] {
		TSR_GR_4K = 2'h0,
		TSR_GR_16K = 2'h1,
		TSR_GR_64K = 2'h2,
		TSR_GR_RSVD = 2'h3
	} tsr_granule_type;
	// Register indices of the context translation control block.
	localparam logic [3:0] TSR_ADDR_CTRL = 4'h0;
	localparam logic [3:0] TSR_ADDR_RANGE = 4'h4;
	localparam logic [3:0] TSR_ADDR_STATUS = 4'h8;
	localparam logic [3:0] TSR_ADDR_WIDTHS = 4'hC;
	// Control register field positions.
	localparam int TSR_CTRL_S1SCH_LSB = 0;
	localparam int TSR_CTRL_S2SCH_LSB = 2;
	localparam int TSR_CTRL_REGIME_LSB = 4;
	localparam int TSR_CTRL_GRAN_LSB = 8;
	localparam int TSR_CTRL_HYPBANK_BIT = 12;
	localparam int TSR_CTRL_MONBANK_BIT = 13;
	localparam int TSR_CTRL_WIDE_BIT = 14;
	localparam int TSR_CTRL_S2GRAN_LSB = 16;
	// Range register field positions.
	localparam int TSR_RANGE_LOW_LSB = 0;
	localparam int TSR_RANGE_UP_LSB = 8;
	// Reset values.
	localparam logic [31:0] TSR_CTRL_RESET = 32'h0000_0000;
	localparam logic [5:0] TSR_SIZE_RESET = 6'h10;
	// Widths of descriptors and addresses.
	localparam logic [6:0] TSR_DESC_32 = 7'h20;
	localparam logic [6:0] TSR_DESC_64 = 7'h40;
	localparam logic [5:0] TSR_OA_SHORT = 6'h20;
	localparam logic [5:0] TSR_OA_SHORT_BIG = 6'h28;
	localparam logic [5:0] TSR_OA_LONG32 = 6'h28;
	localparam logic [5:0] TSR_OA_WIDE64 = 6'h30;
	localparam logic [5:0] TSR_IA_32 = 6'h20;
	localparam logic [5:0] TSR_IA_WIDE64 = 6'h31;
	localparam int TSR_VA_SEL_BIT = 48;
	localparam int TSR_VA_W = 49;
	// Register bus carrier.
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tsr_bus_type;
	// Per-transaction lookup carrier.
	typedef struct packed {
		logic valid;
		logic [63:0] addr;
		logic big_page;
	} tsr_lookup_type;
	// Lookup result carrier.
	typedef struct packed {
		logic valid;
		logic lower_hit;
		logic upper_hit;
		logic fault;
	} tsr_result_type;
endpackage

// [verification/tsr_master_model.sv]
// Upstream master model that issues translation lookups to the selector.
// Assumes the selector takes a lookup on the rising edge of clk while valid is high.
`timescale 1ns/10ps
module tsr_master_model (
	input wire logic clk,
	output tsr_pkg::tsr_lookup_type lookup
);
	import tsr_pkg::*;
	// The port starts idle so no lookup is taken during reset.
	initial begin
		lookup = '0;
	end
	// Issue one lookup after an optional stall, then release the port.
	// The released address is inverted so a stale value never looks like a fresh request.
	task automatic send(input logic [63:0] a, input logic big, input int stall);
		repeat (stall) @(posedge clk);
		@(posedge clk);
		lookup <= '{valid: 1'b1, addr: a, big_page: big};
		@(posedge clk);
		lookup <= '{valid: 1'b0, addr: ~a, big_page: ~big};
		#1;
	endtask
	// Park the page-size hint on an idle port, for width reads that depend on it.
	// Valid stays low, so the selector never takes this as a lookup.
	task automatic set_page(input logic big);
		@(posedge clk);
		lookup <= '{valid: 1'b0, addr: lookup.addr, big_page: big};
	endtask
endmodule

// [verification/tsr_regime_select_tb.sv]
// Self-checking bench for the scheme and regime selector.
// Assumes the master model owns the lookup port and the bench owns the register port.
`timescale 1ns/10ps
module tsr_regime_select_tb;
	import tsr_pkg::*;
	logic clk = 1'b0; // System clock at 100 MHz.
	logic rst_n = 1'b0; // Active low reset, held from time zero.
	tsr_bus_type bus = '0; // Register port request.
	logic [31:0] rdata; // Read data, valid one cycle after the strobe.
	tsr_lookup_type lookup; // Lookup request from the master model.
	tsr_result_type result_reg; // Lookup verdict.
	logic config_error; // Illegal configuration flag.
	logic [1:0] stages; // Stage arrangement.
	int err_count = 0; // Mismatches seen.
	int checks = 0; // Comparisons made.
	// The clock toggles every half period.
	always #5 clk = ~clk;
	tsr_regime_select u_tsr_regime_select (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
		.lookup(lookup), .result_reg(result_reg), .config_error(config_error), .stages(stages));
	tsr_master_model u_tsr_master_model (.clk(clk), .lookup(lookup));
	// Compare a value with its expectation; four-state so an unknown never matches.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Print the counts and the verdict, then end the run.
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// One-cycle write; release lands on the taking edge, so the next request waits an edge.
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask
	// One-cycle read; the data stand only in the cycle after the taking edge.
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'hFFFF_FFFF, wr: 1'b0, rd: 1'b0};
		#1;
		d = rdata;
	endtask
	// Write the control register and let a full cycle pass before looking at the flags.
	task automatic cfg(input logic [31:0] c);
		wr_reg(TSR_ADDR_CTRL, c);
		@(posedge clk);
		#1;
	endtask
	// Reset values, unmapped places and the illegal reset configuration.
	task automatic t_reset();
		logic [31:0] d;
		rd_reg(TSR_ADDR_CTRL, d);
		chk(d, TSR_CTRL_RESET);
		rd_reg(TSR_ADDR_RANGE, d);
		chk(d, {18'h0, TSR_SIZE_RESET, 2'h0, TSR_SIZE_RESET});
		wr_reg(4'h6, 32'hFFFF_FFFF);
		rd_reg(4'h6, d);
		chk(d, 32'h0);
		rd_reg(TSR_ADDR_CTRL, d);
		chk(d, TSR_CTRL_RESET);
		chk(config_error, 1'b1);
	endtask
	// Descriptor, input and output widths of each scheme.
	task automatic t_widths();
		logic [31:0] d;
		logic [31:0] tab [3][2] = '{'{32'h0000_0040, 32'h0020_2020}, '{32'h0000_0041, 32'h0040_2820},
			'{32'h0000_404A, 32'h0040_3031}};
		for (int i = 0; i < 3; i++) begin
			wr_reg(TSR_ADDR_CTRL, tab[i][0]);
			rd_reg(TSR_ADDR_WIDTHS, d);
			chk(d, tab[i][1]);
		end
		// A short-scheme page larger than the granule widens the output to 40 bits.
		u_tsr_master_model.set_page(1'b1);
		wr_reg(TSR_ADDR_CTRL, 32'h0000_0040);
		rd_reg(TSR_ADDR_WIDTHS, d);
		chk(d, 32'h0020_2820);
	endtask
	// Every regime under wide addressing, with the bank each one needs.
	task automatic t_stages();
		logic [31:0] c;
		for (int r = 0; r < 7; r++) begin
			c = 32'h0000_400A | (r << 4);
			if (r == 0) c |= 32'h0000_2000;
			if (r == 2 || r == 3) c |= 32'h0000_1000;
			cfg(c);
			chk(config_error, 1'b0);
			chk(stages, r == 5 ? TSR_ST_S1_S2 : r == 6 ? TSR_ST_S2_ONLY : TSR_ST_S1_BYPASS);
		end
	endtask
	// Legal and illegal scheme, granule and bank combinations.
	task automatic t_legal();
		logic [31:0] tab [11][2] = '{'{32'h0, 32'h1}, '{32'h1020, 32'h1}, '{32'h0051, 32'h1},
			'{32'h0141, 32'h1}, '{32'h4041, 32'h1}, '{32'h1021, 32'h0}, '{32'h0054, 32'h0},
			'{32'h0058, 32'h0}, '{32'h414A, 32'h0}, '{32'h424A, 32'h0}, '{32'h005A, 32'h1}};
		for (int i = 0; i < 11; i++) begin
			cfg(tab[i][0]);
			chk(config_error, tab[i][1][0]);
		end
	endtask
	// Range edges, the gap, the sticky gap flag and a regime without a split.
	task automatic t_ranges();
		logic [31:0] d;
		logic [63:0] tab [6][2] = '{'{64'h0, 64'hC}, '{64'h000F_FFFF, 64'hC}, '{64'h0010_0000, 64'h9},
			'{64'hFFFF_FFFF_FFFF_FFFF, 64'hA}, '{64'hFFFF_FFFF_FFF0_0000, 64'hA},
			'{64'hFFFF_FFFF_FFEF_FFFF, 64'h9}};
		cfg(32'h0000_404A);
		wr_reg(TSR_ADDR_RANGE, 32'h0000_1414);
		for (int i = 0; i < 6; i++) begin
			u_tsr_master_model.send(tab[i][0], 1'b0, i % 2);
			chk(result_reg, tab[i][1]);
		end
		rd_reg(TSR_ADDR_STATUS, d);
		chk(d, 32'h1);
		wr_reg(TSR_ADDR_STATUS, 32'h1);
		rd_reg(TSR_ADDR_STATUS, d);
		chk(d, 32'h0);
		cfg(32'h0000_502A);
		u_tsr_master_model.send(64'hFFFF_FFFF_FFFF_FFFF, 1'b0, 0);
		chk(result_reg, 4'h9);
		u_tsr_master_model.send(64'h0, 1'b0, 0);
		chk(result_reg, 4'hC);
		// The 32-bit long scheme splits the 32-bit range; the gap between the sizes faults.
		cfg(32'h0000_0041);
		u_tsr_master_model.send(64'h0010_0000, 1'b0, 0);
		chk(result_reg, 4'h9);
		u_tsr_master_model.send(64'hFFF0_0000, 1'b0, 1);
		chk(result_reg, 4'hA);
	endtask
	// Main sequence: reset for three cycles, then every scenario in turn.
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_widths();
		t_stages();
		t_legal();
		t_ranges();
		tally_and_finish();
	end
	// A hang is cut short here and counted as a mismatch.
	initial begin
		#500000;
		err_count++;
		tally_and_finish();
	end
endmodule
